// >>> adc_filter_regs.svh
`ifndef ADC_FILTER_REGS_SVH
`define ADC_FILTER_REGS_SVH

// Register byte offsets on the plain register port
`define FLT_CTRL_BASE    8'h00
`define FLT_CTRL_STRIDE  8'h04
`define CONV_TIMING_OFS  8'h20
`define CONV_RESULT_OFS  8'h24
`define FILT_CONFIG_OFS  8'h28
`define IRQ_STATUS_OFS   8'h2c
`define IRQ_MASK_OFS     8'h30

// Filter control register fields
`define FLT_EN_BIT       31
`define FLT_D16_BIT      30
`define FLT_MODE_BIT     29
`define FLT_RATIO_HI     28
`define FLT_RATIO_LO     26
`define FLT_IRQEN_BIT    25
`define FLT_RDY_BIT      24
`define FLT_CHAN_HI      20
`define FLT_CHAN_LO      16
`define FLT_RES_HI       15
`define FLT_RES_LO       0

// Converter timing register fields
`define TIM_EIS_HI       28
`define TIM_EIS_LO       26
`define TIM_RES_HI       25
`define TIM_RES_LO       24
`define TIM_DIV_HI       22
`define TIM_DIV_LO       16
`define TIM_SAMC_HI      9
`define TIM_SAMC_LO      0
`define TIM_RESET        32'h0300_0000

// Config register: fractional output format
`define CFG_FRACTIONAL_FORMAT_SELECT_BIT    0

// Interrupt status layout
`define IRQ_EARLY_BIT    6
`define IRQ_DONE_BIT     7
`define IRQ_WIDTH        8

// Timing counts in converter clocks
`define SAMPLE_EXTRA     11'h002
`define CONV_EXTRA       5'h02

`endif

// >>> adc_filter_pkg.sv
package adc_filter_pkg;

    typedef struct packed {
        logic       enable;
        logic       full_width;
        logic       mode_avg;
        logic [2:0] ratio;
        logic       irq_en;
        logic [4:0] channel;
    } filter_cfg_s;

    typedef struct packed {
        logic [4:0]  channel;
        logic [11:0] data;
    } sample_s;

    typedef struct packed {
        logic [3:0] log2n;
        logic [3:0] shift;
    } ratio_s;

    typedef enum logic [2:0] {
        CONV_IDLE    = 3'b001,
        CONV_SAMPLE  = 3'b010,
        CONV_CONVERT = 3'b100
    } conv_state_e;

    // Sample count (as a power of two) and output shift per mode and code
    function automatic ratio_s ratio_decode(input logic avg, input logic [2:0] code);
        ratio_s r;
        r = '{log2n: 4'h1, shift: 4'h0};
        if (avg) begin
            r.log2n = {1'b0, code} + 4'h1;
            r.shift = {1'b0, code} + 4'h1;
        end else if (code[2]) begin
            r.log2n = {1'b0, code[1:0], 1'b0} + 4'h1;
            r.shift = {2'b00, code[1:0]};
        end else begin
            r.log2n = {1'b0, code[1:0], 1'b0} + 4'h2;
            r.shift = {2'b00, code[1:0]} + 4'h1;
        end
        return r;
    endfunction

endpackage

// >>> adc_filter_unit.sv
`timescale 1ns/1ps
`include "adc_filter_regs.svh"

module adc_filter_unit (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire adc_filter_pkg::filter_cfg_s cfg,
    input  wire logic                       fractional_format_select,
    input  wire logic                       smp_valid,
    input  wire adc_filter_pkg::sample_s    smp,
    input  wire logic                       rd_clear,
    output logic [15:0]                     result,
    output logic                            ready
);
    import adc_filter_pkg::*;

    logic [19:0] acc_reg;
    logic [8:0]  cnt_reg;
    logic [15:0] result_reg;
    logic        ready_reg;

    // Decode of count and shift, and the sum including this sample
    wire ratio_s      rat      = ratio_decode(cfg.mode_avg, cfg.ratio);
    wire              take     = cfg.enable && smp_valid && smp.channel == cfg.channel;
    wire logic [19:0] sum      = acc_reg + {8'h00, smp.data};
    wire logic [8:0]  last_cnt = (9'h001 << rat.log2n) - 9'h001;
    wire              finish   = take && cnt_reg == last_cnt;

    // Oversampling: shifted sum, 16 bits wide
    wire logic [19:0] ovr_full = sum >> rat.shift;
    // Averaging: plain mean, or fraction with 12 or 16 significant bits
    wire logic [23:0] avg_wide = {sum, 4'h0} >> rat.log2n;
    wire logic [19:0] avg_int  = sum >> rat.log2n;
    wire logic [15:0] avg_res  = !fractional_format_select ? {4'h0, avg_int[11:0]} :
                                 cfg.full_width ? avg_wide[15:0] :
                                 {avg_wide[15:4], 4'h0};
    wire logic [15:0] out_val  = cfg.mode_avg ? avg_res : ovr_full[15:0];

    // Accumulate; restart after each result; disable drops the sum and count
    always_ff @(posedge clk) begin
        if (rst || !cfg.enable) begin
            acc_reg <= 20'h00000;
            cnt_reg <= 9'h000;
        end else if (finish) begin
            acc_reg <= 20'h00000;
            cnt_reg <= 9'h000;
        end else if (take) begin
            acc_reg <= sum;
            cnt_reg <= cnt_reg + 9'h001;
        end
    end

    // Result and ready; a new result wins over a read that clears
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg <= 16'h0000;
            ready_reg  <= 1'b0;
        end else if (!cfg.enable) begin
            ready_reg  <= 1'b0;
        end else if (finish) begin
            result_reg <= out_val;
            ready_reg  <= 1'b1;
        end else if (rd_clear) begin
            ready_reg  <= 1'b0;
        end
    end

    assign result = result_reg;
    assign ready  = ready_reg;

endmodule

// >>> adc_filter_timing.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "adc_filter_regs.svh"

// How it works
// - Six filters, each with enable, mode, ratio, channel, irq enable, flag, result.
// - Enable runs a filter; clearing it stops filtering and clears its ready flag.
// - Mode one averages; mode zero, the reset default, oversamples by sum and shift.
// - Fractional averaging: full-width bit gives 16 bits, else 12 bits and four zeros.
// - Oversampling codes 100..111 sum 2,8,32,128 samples, shift 0..3, fixed-point.
// - Oversampling codes 000..011 sum 4,16,64,256 samples, shift 1..4, integer.
// - Averaging codes 000..111 average 2 up to 256 samples.
// - Filter interrupt request follows its ready flag only when irq enable set.
// - Early data-ready comes code+1 converter clocks before conversion end, except code 111 at 6-bit resolution, where it never comes.
// - Resolution select 11,10,01,00 gives 12,10,8,6 bits; reset picks 12.
// - Converter clock period is twice the divisor code in control clocks, and one control clock for code zero.
module adc_filter_timing (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic [31:0]                  rdata,
    input  wire logic                    conv_start,
    input  wire logic                    sample_valid,
    input  wire adc_filter_pkg::sample_s sample_in,
    output logic                         sampling,
    output logic                         converting,
    output logic                         tad_tick,
    output logic                         early_ready,
    output logic                         conv_done,
    output logic                         irq
);
    import adc_filter_pkg::*;

    localparam int NFLT = 6;

    // Filter address match, used by the write and read paths
    function automatic logic flt_hit(input logic [7:0] a, input int idx);
        return a == `FLT_CTRL_BASE + 8'(idx) * `FLT_CTRL_STRIDE;
    endfunction

    filter_cfg_s           cfg_reg [NFLT];
    logic [31:0]           timing_reg;
    logic [11:0]           result_reg;
    logic                  fractional_format_select_reg;
    logic [`IRQ_WIDTH-1:0] status_reg;
    logic [`IRQ_WIDTH-1:0] mask_reg;
    logic [`IRQ_WIDTH-1:0] status_next;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    logic [NFLT-1:0]       req_prev_reg;

    logic [15:0]     flt_result [NFLT];
    logic [NFLT-1:0] flt_ready;
    logic [NFLT-1:0] flt_req;
    logic [NFLT-1:0] flt_rd;

    // Field views of the timing register
    wire logic [2:0] eis  = timing_reg[`TIM_EIS_HI:`TIM_EIS_LO];
    wire logic [1:0] res  = timing_reg[`TIM_RES_HI:`TIM_RES_LO];
    wire logic [6:0] div  = timing_reg[`TIM_DIV_HI:`TIM_DIV_LO];
    wire logic [9:0] samc = timing_reg[`TIM_SAMC_HI:`TIM_SAMC_LO];

    // Resolution masks the unused low bits without shifting the result
    wire logic [11:0] res_mask = res == 2'b11 ? 12'hfff :
                                 res == 2'b10 ? 12'hffc :
                                 res == 2'b01 ? 12'hff0 : 12'hfc0;
    wire sample_s     masked   = '{channel: sample_in.channel,
                                   data: sample_in.data & res_mask};

    // Six filter instances sharing one sample stream
    genvar gi;
    generate
        for (gi = 0; gi < NFLT; gi++) begin : g_flt
            assign flt_rd[gi]  = rd && flt_hit(addr, gi);
            assign flt_req[gi] = flt_ready[gi] && cfg_reg[gi].irq_en;
            adc_filter_unit u_flt (
                .clk       (clk),
                .rst       (rst),
                .cfg       (cfg_reg[gi]),
                .fractional_format_select     (fractional_format_select_reg),
                .smp_valid (sample_valid),
                .smp       (masked),
                .rd_clear  (flt_rd[gi]),
                .result    (flt_result[gi]),
                .ready     (flt_ready[gi])
            );
        end
    endgenerate

    // Converter sequencer: sample phase, then conversion phase
    conv_state_e state_reg;
    conv_state_e state_next;
    logic [7:0]  tq_cnt_reg;
    logic [10:0] sam_cnt_reg;
    logic [4:0]  remain_reg;

    // Divisor zero passes the control clock straight through
    wire logic [7:0] tq_last  = div == 7'h00 ? 8'h00 : {div, 1'b0} - 8'h01;
    wire logic       tick     = state_reg != CONV_IDLE && tq_cnt_reg == tq_last;
    wire logic [4:0] conv_len = {2'b00, res, 1'b0} + 5'h06 + `CONV_EXTRA;
    wire logic [4:0] lead     = {2'b00, eis} + 5'h01;
    wire logic       sam_end  = state_reg == CONV_SAMPLE && tick && sam_cnt_reg == 11'h001;
    wire logic       conv_end = state_reg == CONV_CONVERT && tick && remain_reg == 5'h01;
    // Fires on the tick that leaves lead ticks to go; a lead too large for the
    // resolution never fires, so software keeps the code legal
    wire logic       early    = state_reg == CONV_CONVERT && tick &&
                                remain_reg == lead + 5'h01;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CONV_IDLE:    if (conv_start) state_next = CONV_SAMPLE;
            CONV_SAMPLE:  if (sam_end) state_next = CONV_CONVERT;
            CONV_CONVERT: if (conv_end) state_next = CONV_IDLE;
            default:      state_next = CONV_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= CONV_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Control clock prescaler, restarted at each conversion
    always_ff @(posedge clk) begin
        if (rst || state_reg == CONV_IDLE || tick) begin
            tq_cnt_reg <= 8'h00;
        end else begin
            tq_cnt_reg <= tq_cnt_reg + 8'h01;
        end
    end

    // Sampling and conversion lengths in converter clocks
    always_ff @(posedge clk) begin
        if (rst) begin
            sam_cnt_reg <= 11'h000;
            remain_reg  <= 5'h00;
        end else if (state_reg == CONV_IDLE && conv_start) begin
            sam_cnt_reg <= {1'b0, samc} + `SAMPLE_EXTRA;
        end else if (sam_end) begin
            remain_reg  <= conv_len;
        end else if (tick && state_reg == CONV_SAMPLE) begin
            sam_cnt_reg <= sam_cnt_reg - 11'h001;
        end else if (tick && state_reg == CONV_CONVERT) begin
            remain_reg  <= remain_reg - 5'h01;
        end
    end

    assign sampling    = state_reg == CONV_SAMPLE;
    assign converting  = state_reg == CONV_CONVERT;
    assign tad_tick    = tick;
    assign early_ready = early;
    assign conv_done   = conv_end;

    // Sticky status: a new event wins over a write-one clear
    always_comb begin
        status_next = status_reg;
        if (wr && addr == `IRQ_STATUS_OFS) begin
            status_next = status_reg & ~wdata[`IRQ_WIDTH-1:0];
        end
        status_next[NFLT-1:0]      = status_next[NFLT-1:0] | (flt_req & ~req_prev_reg);
        status_next[`IRQ_EARLY_BIT] = status_next[`IRQ_EARLY_BIT] | early;
        status_next[`IRQ_DONE_BIT]  = status_next[`IRQ_DONE_BIT] | conv_end;
    end

    // Register writes and interrupt bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NFLT; i++) cfg_reg[i] <= '0;
            timing_reg   <= `TIM_RESET;
            fractional_format_select_reg    <= 1'b0;
            mask_reg     <= '0;
            status_reg   <= '0;
            req_prev_reg <= '0;
        end else begin
            for (int i = 0; i < NFLT; i++) begin
                if (wr && flt_hit(addr, i)) begin
                    cfg_reg[i] <= '{enable:     wdata[`FLT_EN_BIT],
                                    full_width: wdata[`FLT_D16_BIT],
                                    mode_avg:   wdata[`FLT_MODE_BIT],
                                    ratio:      wdata[`FLT_RATIO_HI:`FLT_RATIO_LO],
                                    irq_en:     wdata[`FLT_IRQEN_BIT],
                                    channel:    wdata[`FLT_CHAN_HI:`FLT_CHAN_LO]};
                end
            end
            if (wr && addr == `CONV_TIMING_OFS) begin
                timing_reg <= {3'b000, wdata[28:24], 1'b0, wdata[22:16], 6'h00, wdata[9:0]};
            end
            if (wr && addr == `FILT_CONFIG_OFS) fractional_format_select_reg <= wdata[`CFG_FRACTIONAL_FORMAT_SELECT_BIT];
            if (wr && addr == `IRQ_MASK_OFS) mask_reg <= wdata[`IRQ_WIDTH-1:0];
            status_reg   <= status_next;
            req_prev_reg <= flt_req;
        end
    end

    // Latest aligned conversion result
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg <= 12'h000;
        end else if (sample_valid) begin
            result_reg <= masked.data;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        for (int i = 0; i < NFLT; i++) begin
            if (flt_hit(addr, i)) begin
                rdata_next = {cfg_reg[i].enable, cfg_reg[i].full_width, cfg_reg[i].mode_avg,
                              cfg_reg[i].ratio, cfg_reg[i].irq_en, flt_ready[i],
                              3'b000, cfg_reg[i].channel, flt_result[i]};
            end
        end
        case (addr)
            `CONV_TIMING_OFS: rdata_next = timing_reg;
            `CONV_RESULT_OFS: rdata_next = {20'h00000, result_reg};
            `FILT_CONFIG_OFS: rdata_next = {31'h0000_0000, fractional_format_select_reg};
            `IRQ_STATUS_OFS:  rdata_next = {24'h000000, status_reg};
            `IRQ_MASK_OFS:    rdata_next = {24'h000000, mask_reg};
            default:          rdata_next = rdata_next;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !rd) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq   = |(status_reg & mask_reg);

endmodule

// >>> adc_filter_timing_monitor.sv
`timescale 1ns/1ps
`include "adc_filter_regs.svh"

module adc_filter_timing_monitor
    import adc_filter_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [7:0]              addr,
    input wire logic [31:0]             wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [31:0]             rdata,
    input wire logic                    conv_start,
    input wire logic                    sample_valid,
    input wire adc_filter_pkg::sample_s sample_in,
    input wire logic                    sampling,
    input wire logic                    converting,
    input wire logic                    tad_tick,
    input wire logic                    early_ready,
    input wire logic                    conv_done,
    input wire logic                    irq
);
    logic [31:0] tim_reg;
    int          samp_cnt_reg, conv_cnt_reg, lead_cnt_reg;
    int          per, samp_exp, conv_exp, lead_exp;

    // Timing shadow and phase counters; the shadow keeps writable fields only
    always_ff @(posedge clk) begin
        if (rst) begin
            tim_reg      <= `TIM_RESET;
            samp_cnt_reg <= 0;
            conv_cnt_reg <= 0;
            lead_cnt_reg <= 0;
        end else begin
            tim_reg      <= (wr && addr == `CONV_TIMING_OFS) ? wdata & 32'h1f7f_03ff : tim_reg;
            samp_cnt_reg <= sampling ? samp_cnt_reg + 1 : 0;
            conv_cnt_reg <= converting ? conv_cnt_reg + 1 : 0;
            lead_cnt_reg <= early_ready ? 1 : lead_cnt_reg + 1;
        end
    end

    // Expected lengths in control clocks; divisor zero runs at full rate
    assign per      = (tim_reg[22:16] == 7'h00) ? 1 : 2 * int'(tim_reg[22:16]);
    assign samp_exp = (int'(tim_reg[9:0]) + 2) * per;
    assign conv_exp = (8 + 2 * int'(tim_reg[25:24])) * per;
    assign lead_exp = (int'(tim_reg[28:26]) + 1) * per;

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    a_timing_readback: assert property (rd && addr == `CONV_TIMING_OFS |=> rdata == $past(tim_reg))
        else $error("timing word readback wrong");
    a_start_sample: assert property (conv_start && !sampling && !converting |=> sampling)
        else $error("idle start did not begin sampling");
    a_phase_excl: assert property (!(sampling && converting))
        else $error("sampling and converting together");
    a_sample_len: assert property ($fell(sampling) && !$past(rst) |-> samp_cnt_reg == samp_exp)
        else $error("sampling length wrong");
    a_conv_len: assert property ($fell(converting) && !$past(rst) |-> conv_cnt_reg == conv_exp)
        else $error("conversion length wrong");
    a_done_last: assert property (conv_done |-> converting && tad_tick ##1 !converting)
        else $error("done not on last converter clock");
    a_early_lead: assert property (conv_done |-> lead_cnt_reg == lead_exp)
        else $error("early ready lead wrong");
    a_irq_masked: assert property (wr && addr == `IRQ_MASK_OFS && wdata[7:0] == 8'h00 |=> !irq)
        else $error("irq high with all masked");
endmodule

bind adc_filter_timing adc_filter_timing_monitor adc_filter_timing_monitor_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .conv_start(conv_start), .sample_valid(sample_valid), .sample_in(sample_in),
    .sampling(sampling), .converting(converting), .tad_tick(tad_tick),
    .early_ready(early_ready), .conv_done(conv_done), .irq(irq)
);

// >>> adc_core_model.sv
`timescale 1ns/1ps

module adc_core_model
    import adc_filter_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               slow,
    output logic                    sample_valid,
    output adc_filter_pkg::sample_s sample_in
);
    sample_s q[$];
    int      gap = 0;

    // Bench hands samples over through this queue
    task automatic push(input sample_s s);
        q.push_back(s);
    endtask

    initial begin
        sample_valid = 1'b0;
        sample_in    = '0;
    end

    // One sample per slot, gaps when slow; an idle bus inverts its word every cycle,
    // so it shows the last word and its inverse in turn, with valid held low
    always @(posedge clk) begin
        if (rst || q.size() == 0 || gap > 0) begin
            gap          <= (gap > 0) ? gap - 1 : 0;
            sample_valid <= 1'b0;
            sample_in    <= ~sample_in;
        end else begin
            gap          <= slow ? q.size() % 3 : 0;
            sample_valid <= 1'b1;
            sample_in    <= q.pop_front();
        end
    end
endmodule

// >>> adc_filter_and_timing_control_tb.sv
`timescale 1ns/1ps
`include "adc_filter_regs.svh"

module adc_filter_and_timing_control_tb;
    import adc_filter_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, conv_start = 0, slow = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got, ctl, exp_w;
    logic        sample_valid, sampling, converting, tad_tick, early_ready, conv_done, irq;
    sample_s     sample_in;
    int          error_cnt = 0, n_checks = 0, seed = 38287, res_code = 3;
    int          ns, nc, cyc, t_e, t_d, per, cres;
    int          osr_n[8] = '{4, 16, 64, 256, 2, 8, 32, 128};
    int          osr_sh[8] = '{1, 2, 3, 4, 0, 1, 2, 3};
    int          seq_t[4][4] = '{'{1, 0, 3, 0}, '{3, 5, 0, 3}, '{0, 1, 1, 5}, '{2, 3, 2, 7}};

    adc_filter_timing adc_filter_timing_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .conv_start(conv_start), .sample_valid(sample_valid), .sample_in(sample_in),
        .sampling(sampling), .converting(converting), .tad_tick(tad_tick),
        .early_ready(early_ready), .conv_done(conv_done), .irq(irq)
    );
    adc_core_model adc_core_model_inst (
        .clk(clk), .rst(rst), .slow(slow), .sample_valid(sample_valid), .sample_in(sample_in)
    );

    always #25 clk = ~clk;

    // Phase counters, sampled mid-cycle away from the launching edge
    always @(negedge clk) begin
        cyc++;
        ns += sampling;
        nc += converting;
        if (early_ready) t_e = cyc;
        if (conv_done) t_d = cyc;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
        n_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic bound(input int w, input int lim);
        if (w >= lim) begin
            check("wait bound", 32'h0, 32'h1);
            final_report();
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Stream n own-channel samples, each followed by a foreign one
    task automatic feed(input int k, input int fractional_format_select);
        int n, d, sum;
        n = ctl[29] ? 2 << ctl[28:26] : osr_n[ctl[28:26]];
        sum = 0;
        reg_wr(8'(4 * k), ctl);
        for (int i = 0; i < n; i++) begin
            d = $random(seed) & 32'hfff;
            sum += d & (32'hfff << (6 - 2 * res_code)) & 32'hfff;
            adc_core_model_inst.push('{channel: ctl[20:16], data: 12'(d)});
            adc_core_model_inst.push('{channel: ~ctl[20:16], data: 12'(~d)});
            cres = ~d & (32'hfff << (6 - 2 * res_code)) & 32'hfff;
        end
        for (d = 0; d < 9000 && adc_core_model_inst.q.size() != 0; d++) @(posedge clk);
        bound(d, 9000);
        repeat (4) @(posedge clk);
        sum = !ctl[29] ? sum >> osr_sh[ctl[28:26]] : !fractional_format_select ? sum / n :
              ctl[30] ? sum * 16 / n : sum / n * 16;
        exp_w = ctl | 32'h0100_0000 | 16'(sum);
    endtask

    task automatic run(input int k, input int fractional_format_select);
        feed(k, fractional_format_select);
        reg_rd(8'(4 * k), got);
        check("filter word", exp_w, got);
        reg_rd(8'(4 * k), got);
        check("ready after read", 32'h0, got & 32'h0100_0000);
        reg_wr(8'(4 * k), 32'h0);
    endtask

    initial begin
        int w;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`CONV_TIMING_OFS, got);
        check("timing reset", `TIM_RESET, got);
        reg_rd(`FLT_CTRL_BASE, got);
        check("filter reset", 32'h0, got);
        reg_wr(8'h40, 32'hffff_ffff);
        reg_rd(8'h40, got);
        check("unmapped", 32'h0, got);
        // Every ratio code in both modes, spread over the six filters
        for (int i = 0; i < 16; i++) begin
            slow <= i[0];
            ctl = {2'b10, 1'(i >> 3), 3'(i), 5'h00, 5'($random(seed)), 16'h0};
            run(i % 6, 0);
        end
        // Fractional averaging with twelve and sixteen significant bits
        reg_wr(`FILT_CONFIG_OFS, 32'h1);
        for (int f = 0; f < 2; f++) begin
            ctl = {1'b1, 1'(f), 4'b1001, 5'h00, 5'h07, 16'h0};
            run(2, 1);
        end
        reg_wr(`FILT_CONFIG_OFS, 32'h0);
        // Six-bit resolution keeps samples left-aligned
        reg_wr(`CONV_TIMING_OFS, 32'h0);
        res_code = 0;
        ctl = {2'b10, 4'b1001, 5'h00, 5'h03, 16'h0};
        run(4, 0);
        reg_rd(`CONV_RESULT_OFS, got);
        check("conversion result", 32'(cres), got);
        res_code = 3;
        reg_wr(`CONV_TIMING_OFS, `TIM_RESET);
        // Disabling drops a pending ready flag
        ctl = {2'b10, 4'b0100, 5'h00, 5'h11, 16'h0};
        feed(5, 0);
        reg_wr(8'h14, ctl & 32'h7fff_ffff);
        reg_rd(8'h14, got);
        check("ready on disable", 32'h0, got & 32'h0100_0000);
        // Filter interrupt with and without its enable, cleared by a one
        reg_wr(`IRQ_MASK_OFS, 32'hff);
        for (int e = 1; e >= 0; e--) begin
            ctl = {2'b10, 4'b1000, 1'(e), 4'h0, 5'h09, 16'h0};
            run(3, 0);
            reg_rd(`IRQ_STATUS_OFS, got);
            check("filter irq flag", 32'(e) << 3, got);
            check("irq line", 32'(e), 32'(irq));
            reg_wr(`IRQ_MASK_OFS, 32'h0);
            @(negedge clk);
            check("irq masked", 32'h0, 32'(irq));
            reg_wr(`IRQ_MASK_OFS, 32'hff);
            reg_wr(`IRQ_STATUS_OFS, 32'hff);
            repeat (2) @(posedge clk);
            check("irq cleared", 32'h0, 32'(irq));
        end
        // Conversions; starts held while busy must be ignored
        for (int j = 0; j < 4; j++) begin
            reg_wr(`CONV_TIMING_OFS, {3'h0, 3'(seq_t[j][3]), 2'(seq_t[j][2]), 1'b0,
                                      7'(seq_t[j][0]), 6'h0, 10'(seq_t[j][1])});
            per = (seq_t[j][0] == 0) ? 1 : 2 * seq_t[j][0];
            @(posedge clk);
            {ns, nc, t_e, t_d} = 128'h0;
            conv_start <= 1'b1;
            repeat (3) @(posedge clk);
            conv_start <= 1'b0;
            for (w = 0; w < 30000 && (t_d == 0 || converting); w++) @(posedge clk);
            bound(w, 30000);
            check("sample cycles", (seq_t[j][1] + 2) * per, ns);
            check("convert cycles", (8 + 2 * seq_t[j][2]) * per, nc);
            check("early lead", (seq_t[j][3] + 1) * per, t_d - t_e);
            reg_rd(`IRQ_STATUS_OFS, got);
            check("event flags", 32'hc0, got);
            reg_wr(`IRQ_STATUS_OFS, 32'hff);
        end
        final_report();
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge clk);
        bound(1, 0);
    end
endmodule
